//--- spi_access_pkg.sv
// Shared constants and types of the serial access logic
package spi_access_pkg;

  // RAM layout
  localparam int RAM_BYTES = 368;
  localparam int QUEUE_BYTES = 128;
  localparam int SEC_BYTES = 112;
  localparam logic [1:0] BANK_TXQ = 2'h0;
  localparam logic [1:0] BANK_RXQ = 2'h1;
  localparam logic [8:0] LONG_ID_BASE = 9'h160;
  localparam logic [8:0] NET_ID_BASE = 9'h168;
  localparam logic [8:0] SHORT_ID_BASE = 9'h16A;
  localparam int ID_BYTES = 12;

  // Access addresses
  localparam logic [5:0] ADDR_TXQ_PORT = 6'h3E;
  localparam logic [5:0] ADDR_RXQ_PORT = 6'h3F;
  localparam logic [5:0] STROBE_LAST = 6'h0E;

  // Strobe codes
  localparam logic [5:0] STB_NO_OP = 6'h00;
  localparam logic [5:0] STB_OSC_ON = 6'h01;
  localparam logic [5:0] STB_FLUSH_RX = 6'h08;
  localparam logic [5:0] STB_FLUSH_TX = 6'h09;

  // Status word bit positions
  localparam int ST_OSC = 6;
  localparam int ST_UNDER = 5;
  localparam int ST_CIPHER = 4;
  localparam int ST_TXACT = 3;
  localparam int ST_LOCK = 2;
  localparam int ST_RSSI = 1;

  // Reset values
  localparam logic [2:0] PIN_RESET = 3'h4;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // Timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int RSSI_SETTLE_NS = 128000;
  localparam int RSSI_SETTLE_CYCLES = (RSSI_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int TXQ_BUF_DEPTH = 4;

  typedef enum {
    PS_FIRST,
    PS_REG_HI,
    PS_REG_LO,
    PS_RAM_BANK,
    PS_RAM_DATA,
    PS_TXQ,
    PS_RXQ
  } parse_e;

endpackage

//--- pin_sync.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      meta_reg <= RESET_VAL;
      q <= RESET_VAL;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule

//--- byte_fifo.sv
// Small FIFO with valid and ready on both sides
`timescale 1ns/1ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("byte_fifo depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] store [0:DEPTH-1];
  logic [PW-1:0] wptr_reg;
  logic [PW-1:0] rptr_reg;
  logic [PW:0] count_reg;
  logic push;
  logic pop;

  assign in_ready = (count_reg != (PW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data = store[rptr_reg];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_ff @(posedge CLK) begin
    if (push) begin
      store[wptr_reg] <= in_data;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      count_reg <= '0;
    end else if (flush) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wptr_reg <= wptr_reg + 1'b1;
      end
      if (pop) begin
        rptr_reg <= rptr_reg + 1'b1;
      end
      count_reg <= count_reg + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule

//--- spi_strobe_ram_fifo_access.sv
// Serial slave access logic: status, strobes, RAM and queue ports
`timescale 1ns/1ps
module spi_strobe_ram_fifo_access
  import spi_access_pkg::*;
#(
  parameter int RSSI_CYCLES = RSSI_SETTLE_CYCLES,
  parameter int BUF_DEPTH = TXQ_BUF_DEPTH
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic SCLK,
  input wire logic SI,
  input wire logic CS_N,
  output logic SO_OUT,
  output logic SO_OE_N,
  input wire logic OSC_STABLE,
  input wire logic CIPHER_BUSY,
  input wire logic TX_ACTIVE,
  input wire logic SYNTH_LOCK,
  input wire logic RX_ENABLED,
  output logic STROBE_PULSE,
  output logic [5:0] STROBE_CODE,
  output logic REG_WE,
  output logic REG_RE,
  output logic [5:0] REG_ADDR,
  output logic [15:0] REG_WDATA,
  input wire logic [15:0] REG_RDATA,
  output logic [7:0] TXQ_DATA,
  output logic TXQ_VALID,
  input wire logic TXQ_READY,
  input wire logic RXQ_WE,
  input wire logic [7:0] RXQ_DATA,
  output logic [63:0] LONG_NODE_ID,
  output logic [15:0] NETWORK_ID,
  output logic [15:0] SHORT_NODE_ID
);
  localparam int RW = $clog2(RSSI_CYCLES + 1);

  if (RSSI_CYCLES < 1) begin : g_bad_rssi
    $error("RSSI_CYCLES must be at least 1");
  end

  logic cs_n_s;
  logic sclk_s;
  logic si_s;
  logic sclk_d_reg;
  logic cs_n_d_reg;
  logic rise;
  logic fall;
  logic cs_start;
  logic [6:0] in_reg;
  logic [2:0] bit_cnt_reg;
  logic byte_done;
  logic [7:0] in_byte;
  parse_e state_reg;
  logic load_pend_reg;
  logic strobe_pend_reg;
  logic [5:0] strobe_code_reg;
  logic reg_read_reg;
  logic q_read_reg;
  logic [7:0] wdata_hi_reg;
  logic [7:0] rdata_lo_reg;
  logic [8:0] ram_addr_reg;
  logic ram_ro_reg;
  logic [7:0] out_reg;
  logic [7:0] next_byte;
  logic [7:0] status;
  logic [7:0] mem [0:RAM_BYTES-1];
  logic [6:0] tx_wptr_reg;
  logic [6:0] tx_rptr_reg;
  logic [7:0] tx_count_reg;
  logic [6:0] rx_wptr_reg;
  logic [6:0] rx_rptr_reg;
  logic [7:0] rx_count_reg;
  logic under_reg;
  logic [RW-1:0] rssi_cnt_reg;
  logic signal_strength_valid_flag_reg;
  logic strobe_fire;
  logic flush_tx;
  logic flush_rx;
  logic ram_wr;
  logic txq_wr;
  logic rxq_wr;
  logic rxq_rd;
  logic modem_wr;
  logic fill;
  logic buf_in_ready;
  logic [95:0] id_reg;

  pin_sync #(.W(3), .RESET_VAL(PIN_RESET)) u_sync (
    .CLK(CLK),
    .RST(RST),
    .d({CS_N, SCLK, SI}),
    .q({cs_n_s, sclk_s, si_s})
  );

  // Edge detection on synchronised pins
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      sclk_d_reg <= 1'b0;
      cs_n_d_reg <= 1'b1;
    end else begin
      sclk_d_reg <= sclk_s;
      cs_n_d_reg <= cs_n_s;
    end
  end

  assign rise = sclk_s & ~sclk_d_reg & ~cs_n_s;
  assign fall = ~sclk_s & sclk_d_reg & ~cs_n_s;
  assign cs_start = cs_n_d_reg & ~cs_n_s;
  assign byte_done = rise & (bit_cnt_reg == 3'h7);
  assign in_byte = {in_reg, si_s};

  // Status word
  always_comb begin
    status = 8'h00;
    status[ST_OSC] = OSC_STABLE;
    status[ST_UNDER] = under_reg;
    status[ST_CIPHER] = CIPHER_BUSY;
    status[ST_TXACT] = TX_ACTIVE;
    status[ST_LOCK] = SYNTH_LOCK;
    status[ST_RSSI] = signal_strength_valid_flag_reg;
  end

  // Input shift register
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      in_reg <= 7'h00;
      bit_cnt_reg <= 3'h0;
    end else if (cs_n_s) begin
      bit_cnt_reg <= 3'h0;
    end else if (rise) begin
      in_reg <= {in_reg[5:0], si_s};
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
    end
  end

  // Access parser
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state_reg <= PS_FIRST;
      reg_read_reg <= 1'b0;
      q_read_reg <= 1'b0;
      REG_ADDR <= 6'h00;
      wdata_hi_reg <= BYTE_RESET;
      ram_addr_reg <= 9'h000;
      ram_ro_reg <= 1'b0;
    end else if (cs_n_s) begin
      state_reg <= PS_FIRST;
    end else if (byte_done) begin
      case (state_reg)
        PS_FIRST: begin
          if (in_byte[7]) begin
            ram_addr_reg <= {2'h0, in_byte[6:0]};
            state_reg <= PS_RAM_BANK;
          end else if (in_byte[5:0] == ADDR_TXQ_PORT) begin
            q_read_reg <= in_byte[6];
            state_reg <= PS_TXQ;
          end else if (in_byte[5:0] == ADDR_RXQ_PORT) begin
            q_read_reg <= in_byte[6];
            state_reg <= PS_RXQ;
          end else if (in_byte[5:0] <= STROBE_LAST && !in_byte[6]) begin
            state_reg <= PS_FIRST;
          end else begin
            reg_read_reg <= in_byte[6];
            REG_ADDR <= in_byte[5:0];
            state_reg <= PS_REG_HI;
          end
        end
        PS_REG_HI: begin
          wdata_hi_reg <= in_byte;
          state_reg <= PS_REG_LO;
        end
        PS_REG_LO: begin
          state_reg <= PS_FIRST;
        end
        PS_RAM_BANK: begin
          ram_addr_reg[8:7] <= in_byte[7:6];
          ram_ro_reg <= in_byte[5];
          state_reg <= PS_RAM_DATA;
        end
        PS_RAM_DATA: begin
          ram_addr_reg <= ram_addr_reg + 9'h001;
        end
        PS_TXQ, PS_RXQ: begin
          state_reg <= state_reg;
        end
        default: begin
          state_reg <= PS_FIRST;
        end
      endcase
    end
  end

  // Register access strobes
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      REG_WE <= 1'b0;
      REG_RE <= 1'b0;
      REG_WDATA <= 16'h0000;
    end else begin
      REG_RE <= byte_done & (state_reg == PS_FIRST) & ~in_byte[7] & in_byte[6]
                & (in_byte[5:1] != 5'h1F);
      REG_WE <= byte_done & (state_reg == PS_REG_LO) & ~reg_read_reg;
      if (byte_done && state_reg == PS_REG_LO) begin
        REG_WDATA <= {wdata_hi_reg, in_byte};
      end
    end
  end

  // Strobe capture and execution
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      strobe_pend_reg <= 1'b0;
      strobe_code_reg <= 6'h00;
      STROBE_PULSE <= 1'b0;
      STROBE_CODE <= 6'h00;
    end else begin
      STROBE_PULSE <= strobe_fire & (strobe_code_reg != STB_NO_OP);
      if (strobe_fire) begin
        STROBE_CODE <= strobe_code_reg;
      end
      if (cs_n_s) begin
        strobe_pend_reg <= 1'b0;
      end else if (byte_done && state_reg == PS_FIRST && !in_byte[7]
                   && !in_byte[6] && in_byte[5:0] <= STROBE_LAST) begin
        strobe_pend_reg <= 1'b1;
        strobe_code_reg <= in_byte[5:0];
      end else if (fall) begin
        strobe_pend_reg <= 1'b0;
      end
    end
  end

  assign strobe_fire = fall & strobe_pend_reg
                       & (OSC_STABLE | (strobe_code_reg == STB_OSC_ON));
  assign flush_tx = strobe_fire & (strobe_code_reg == STB_FLUSH_TX);
  assign flush_rx = strobe_fire & (strobe_code_reg == STB_FLUSH_RX);

  // Next outgoing byte, sampled at the byte boundary
  always_comb begin
    next_byte = 8'h00;
    case (state_reg)
      PS_FIRST: next_byte = status;
      PS_REG_HI: next_byte = reg_read_reg ? REG_RDATA[15:8] : 8'h00;
      PS_REG_LO: next_byte = reg_read_reg ? rdata_lo_reg : 8'h00;
      PS_RAM_BANK: next_byte = 8'h00;
      PS_RAM_DATA: begin
        if (ram_addr_reg < 9'(RAM_BYTES)) begin
          next_byte = mem[ram_addr_reg];
        end
      end
      PS_TXQ: next_byte = status;
      PS_RXQ: next_byte = mem[{BANK_RXQ, rx_rptr_reg}];
      default: next_byte = 8'h00;
    endcase
  end

  // Serial output shifter
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      out_reg <= 8'h00;
      SO_OUT <= 1'b0;
      SO_OE_N <= 1'b1;
      load_pend_reg <= 1'b0;
      rdata_lo_reg <= BYTE_RESET;
    end else if (cs_n_s) begin
      SO_OE_N <= 1'b1;
      load_pend_reg <= 1'b0;
    end else if (cs_start) begin
      SO_OE_N <= 1'b0;
      SO_OUT <= status[7];
      out_reg <= {status[6:0], 1'b0};
    end else begin
      if (byte_done) begin
        load_pend_reg <= 1'b1;
      end else if (fall) begin
        load_pend_reg <= 1'b0;
      end
      if (fall && load_pend_reg) begin
        SO_OUT <= next_byte[7];
        out_reg <= {next_byte[6:0], 1'b0};
        if (state_reg == PS_REG_HI) begin
          rdata_lo_reg <= REG_RDATA[7:0];
        end
      end else if (fall) begin
        SO_OUT <= out_reg[7];
        out_reg <= {out_reg[6:0], 1'b0};
      end
    end
  end

  // Queue and RAM read and write qualifiers
  assign ram_wr = byte_done & (state_reg == PS_RAM_DATA) & ~ram_ro_reg
                  & (ram_addr_reg < 9'(RAM_BYTES));
  assign txq_wr = byte_done & (state_reg == PS_TXQ) & ~q_read_reg
                  & (tx_count_reg < 8'(QUEUE_BYTES));
  assign rxq_wr = byte_done & (state_reg == PS_RXQ) & ~q_read_reg
                  & (rx_count_reg < 8'(QUEUE_BYTES));
  assign rxq_rd = byte_done & (state_reg == PS_RXQ) & q_read_reg & (rx_count_reg != 8'h00);
  assign modem_wr = RXQ_WE & ~rxq_wr & (rx_count_reg < 8'(QUEUE_BYTES));
  assign fill = (tx_count_reg != 8'h00) & buf_in_ready & ~flush_tx;

  // Shared RAM
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      for (int i = 0; i < RAM_BYTES; i++) begin
        mem[i] <= 8'h00;
      end
    end else begin
      if (ram_wr) begin
        mem[ram_addr_reg] <= in_byte;
      end
      if (txq_wr) begin
        mem[{BANK_TXQ, tx_wptr_reg}] <= in_byte;
      end
      if (rxq_wr) begin
        mem[{BANK_RXQ, rx_wptr_reg}] <= in_byte;
      end else if (modem_wr) begin
        mem[{BANK_RXQ, rx_wptr_reg}] <= RXQ_DATA;
      end
    end
  end

  // Transmit queue pointers
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      tx_wptr_reg <= 7'h00;
      tx_rptr_reg <= 7'h00;
      tx_count_reg <= 8'h00;
    end else if (flush_tx) begin
      tx_wptr_reg <= 7'h00;
      tx_rptr_reg <= 7'h00;
      tx_count_reg <= 8'h00;
    end else begin
      if (txq_wr) begin
        tx_wptr_reg <= tx_wptr_reg + 7'h01;
      end
      if (fill) begin
        tx_rptr_reg <= tx_rptr_reg + 7'h01;
      end
      tx_count_reg <= tx_count_reg + 8'(txq_wr) - 8'(fill);
    end
  end

  // Receive queue pointers
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      rx_wptr_reg <= 7'h00;
      rx_rptr_reg <= 7'h00;
      rx_count_reg <= 8'h00;
    end else if (flush_rx) begin
      rx_wptr_reg <= 7'h00;
      rx_rptr_reg <= 7'h00;
      rx_count_reg <= 8'h00;
    end else begin
      if (rxq_wr || modem_wr) begin
        rx_wptr_reg <= rx_wptr_reg + 7'h01;
      end
      if (rxq_rd) begin
        rx_rptr_reg <= rx_rptr_reg + 7'h01;
      end
      rx_count_reg <= rx_count_reg + 8'(rxq_wr | modem_wr) - 8'(rxq_rd);
    end
  end

  byte_fifo #(.WIDTH(8), .DEPTH(BUF_DEPTH)) u_txbuf (
    .CLK(CLK),
    .RST(RST),
    .flush(flush_tx),
    .in_valid(fill),
    .in_ready(buf_in_ready),
    .in_data(mem[{BANK_TXQ, tx_rptr_reg}]),
    .out_valid(TXQ_VALID),
    .out_ready(TXQ_READY),
    .out_data(TXQ_DATA)
  );

  // Underflow flag; a new underflow wins over the flush
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      under_reg <= 1'b0;
    end else begin
      under_reg <= (TX_ACTIVE & TXQ_READY & ~TXQ_VALID) | (under_reg & ~flush_tx);
    end
  end

  // Signal strength settle timer
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      rssi_cnt_reg <= '0;
      signal_strength_valid_flag_reg <= 1'b0;
    end else if (!RX_ENABLED) begin
      rssi_cnt_reg <= '0;
      signal_strength_valid_flag_reg <= 1'b0;
    end else if (rssi_cnt_reg != RW'(RSSI_CYCLES)) begin
      rssi_cnt_reg <= rssi_cnt_reg + 1'b1;
    end else begin
      signal_strength_valid_flag_reg <= 1'b1;
    end
  end

  // Identifier copies from the security bank
  for (genvar g = 0; g < ID_BYTES; g++) begin : g_id
    always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
        id_reg[g*8 +: 8] <= 8'h00;
      end else begin
        id_reg[g*8 +: 8] <= mem[LONG_ID_BASE + 9'(g)];
      end
    end
  end

  assign LONG_NODE_ID = id_reg[63:0];
  assign NETWORK_ID = id_reg[(NET_ID_BASE - LONG_ID_BASE)*8 +: 16];
  assign SHORT_NODE_ID = id_reg[(SHORT_ID_BASE - LONG_ID_BASE)*8 +: 16];

endmodule

//--- spi_host_model.sv
// Host serial master model that drives the link
`timescale 1ns/1ps
module spi_host_model (
  input wire logic CLK,
  input wire logic SO_LINE,
  output logic SCLK,
  output logic SI,
  output logic CS_N
);
  initial begin
    SCLK = 1'b0;
    SI = 1'b0;
    CS_N = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask
  // Select or release, with margins around the edge
  task automatic sel(input logic on);
    tick(4);
    CS_N = !on;
    tick(6);
  endtask
  task automatic xfer(input logic [7:0] o, input int n, output logic [7:0] r);
    r = 8'h00;
    for (int k = 7; k > 7 - n; k--) begin
      SI = o[k];
      tick(4);
      SCLK = 1'b1;
      r[k] = SO_LINE;
      tick(4);
      SCLK = 1'b0;
    end
  endtask
endmodule

//--- spi_access_sva.sv
// Port checker of the serial access block
`timescale 1ns/1ps
module spi_access_sva
  import spi_access_pkg::*;
#(
  parameter int RSSI_CYCLES = RSSI_SETTLE_CYCLES,
  parameter int BUF_DEPTH = TXQ_BUF_DEPTH
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic CS_N,
  input wire logic SO_OE_N,
  input wire logic OSC_STABLE,
  input wire logic STROBE_PULSE,
  input wire logic [5:0] STROBE_CODE,
  input wire logic REG_WE,
  input wire logic REG_RE,
  input wire logic [5:0] REG_ADDR,
  input wire logic TXQ_VALID,
  input wire logic TXQ_READY,
  input wire logic [63:0] LONG_NODE_ID
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);
  oe_float_a: assert property (CS_N [*4] |-> SO_OE_N)
    else $error("output driven while deselected");
  oe_drive_a: assert property (!CS_N [*4] |-> !SO_OE_N)
    else $error("output not driven while selected");
  pulse_single_a: assert property (STROBE_PULSE |=> !STROBE_PULSE)
    else $error("strobe pulse too long");
  strobe_code_a: assert property (STROBE_PULSE |-> STROBE_CODE != STB_NO_OP && STROBE_CODE <= STROBE_LAST)
    else $error("bad strobe code executed");
  osc_gate_a: assert property (STROBE_PULSE && STROBE_CODE != STB_OSC_ON |-> $past(OSC_STABLE))
    else $error("strobe executed without oscillator");
  we_frame_a: assert property (REG_WE |-> !CS_N && !REG_RE)
    else $error("register write outside a frame");
  re_port_a: assert property (REG_RE |-> REG_ADDR != ADDR_TXQ_PORT && REG_ADDR != ADDR_RXQ_PORT)
    else $error("queue port read as register");
  id_hold_a: assert property (CS_N [*4] |-> $stable(LONG_NODE_ID))
    else $error("identifier changed while idle");
  strobe_c: cover property (STROBE_PULSE);
  write_c: cover property (REG_WE);
  read_c: cover property (REG_RE);
  drain_c: cover property (TXQ_VALID && TXQ_READY);
endmodule
bind spi_strobe_ram_fifo_access spi_access_sva #(.RSSI_CYCLES(RSSI_CYCLES), .BUF_DEPTH(BUF_DEPTH))
  i_sva (.CLK, .RST, .CS_N, .SO_OE_N, .OSC_STABLE, .STROBE_PULSE, .STROBE_CODE, .REG_WE,
  .REG_RE, .REG_ADDR, .TXQ_VALID, .TXQ_READY, .LONG_NODE_ID);

//--- spi_strobe_ram_fifo_access_test.sv
// Self-checking bench of the serial access block
`timescale 1ns/1ps
module spi_strobe_ram_fifo_access_test
  import spi_access_pkg::*;
;
  typedef struct {logic [4:0] in; logic [7:0] cmd; logic [7:0] st; logic pl;} row_s;
  logic clk, rst, sclk, si, cs_n, so_out, so_oe_n, osc, cipher, txact, lock, rxen;
  logic stb, reg_we, reg_re, txq_valid, txq_ready, rxq_we;
  logic [5:0] stb_code, reg_addr, code_seen, wa_seen, ra_seen;
  logic [15:0] reg_wdata, wd_seen, reg_rdata, net_id, short_id;
  logic [7:0] txq_data, rxq_data, r;
  logic [63:0] long_id;
  int n_fail = 0;
  int cmp_count = 0;
  int npulse = 0;
  int p0;
  logic [7:0] drained[$];
  row_s rows[6] = '{'{5'h08, 8'h09, 8'h10, 1'b0}, '{5'h00, 8'h01, 8'h00, 1'b1},
    '{5'h12, 8'h00, 8'h44, 1'b0}, '{5'h14, 8'h08, 8'h48, 1'b1},
    '{5'h18, 8'h0E, 8'h50, 1'b1}, '{5'h11, 8'h09, 8'h42, 1'b1}};
  wire so_line = so_oe_n ? 1'b1 : so_out;
  spi_host_model i_host (.CLK(clk), .SO_LINE(so_line), .SCLK(sclk), .SI(si), .CS_N(cs_n));
  spi_strobe_ram_fifo_access #(.RSSI_CYCLES(20), .BUF_DEPTH(4)) i_dut (.CLK(clk), .RST(rst),
    .SCLK(sclk), .SI(si), .CS_N(cs_n), .SO_OUT(so_out), .SO_OE_N(so_oe_n),
    .OSC_STABLE(osc), .CIPHER_BUSY(cipher), .TX_ACTIVE(txact), .SYNTH_LOCK(lock),
    .RX_ENABLED(rxen), .STROBE_PULSE(stb), .STROBE_CODE(stb_code), .REG_WE(reg_we),
    .REG_RE(reg_re), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata),
    .TXQ_DATA(txq_data), .TXQ_VALID(txq_valid), .TXQ_READY(txq_ready), .RXQ_WE(rxq_we),
    .RXQ_DATA(rxq_data), .LONG_NODE_ID(long_id), .NETWORK_ID(net_id),
    .SHORT_NODE_ID(short_id));
  initial begin
    clk = 1'b0;
    forever #10 clk = !clk;
  end
  always @(posedge clk) begin
    if (stb === 1'b1) begin
      npulse++;
      code_seen <= stb_code;
    end
    if (reg_re === 1'b1)
      ra_seen <= reg_addr;
    if (reg_we === 1'b1) begin
      wa_seen <= reg_addr;
      wd_seen <= reg_wdata;
    end
    if (txq_valid === 1'b1 && txq_ready === 1'b1)
      drained.push_back(txq_data);
  end
  task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_port(input logic [63:0] g, input logic [63:0] e);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic one(input logic [7:0] c, input logic [7:0] e);
    i_host.sel(1'b1);
    i_host.xfer(c, 8, r);
    i_host.sel(1'b0);
    chk_byte(r, e);
  endtask
  task automatic final_report();
    if (n_fail == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    n_fail++;
    final_report();
  end
  initial begin
    rst = 1'b1;
    {osc, cipher, txact, lock, rxen} = 5'h00;
    {txq_ready, rxq_we, rxq_data} = 10'h000;
    reg_rdata = 16'hC3A7;
    i_host.tick(2);
    rst = 1'b0;
    i_host.tick(4);
    foreach (rows[i]) begin
      {osc, cipher, txact, lock, rxen} = rows[i].in;
      i_host.tick(30);
      p0 = npulse;
      one(rows[i].cmd, rows[i].st);
      chk_port(64'(npulse - p0), 64'(rows[i].pl));
      if (rows[i].pl)
        chk_port(code_seen, rows[i].cmd);
    end
    {osc, cipher, txact, lock, rxen} = 5'h10;
    i_host.sel(1'b1);
    i_host.xfer(8'h15, 8, r);
    chk_byte(r, 8'h40);
    i_host.xfer(8'hA5, 8, r);
    i_host.xfer(8'h3C, 8, r);
    chk_port({wa_seen, wd_seen}, {6'h15, 16'hA53C});
    i_host.xfer(8'h55, 8, r);
    chk_byte(r, 8'h40);
    i_host.xfer(8'h00, 8, r);
    chk_byte(r, 8'hC3);
    chk_port(ra_seen, 6'h15);
    i_host.xfer(8'h00, 8, r);
    chk_byte(r, 8'hA7);
    i_host.xfer(8'h3E, 8, r);
    for (int k = 0; k < 5; k++) begin
      i_host.xfer(8'hA0 + 8'(k), 8, r);
      chk_byte(r, 8'h40);
    end
    i_host.sel(1'b0);
    chk_port(txq_valid, 1'b1);
    i_host.sel(1'b1);
    i_host.xfer(8'h80, 8, r);
    i_host.xfer(8'h20, 8, r);
    for (int k = 0; k < 5; k++) begin
      i_host.xfer(8'h00, 8, r);
      chk_byte(r, 8'hA0 + 8'(k));
    end
    i_host.sel(1'b0);
    txq_ready = 1'b1;
    i_host.tick(20);
    chk_port(drained.size(), 5);
    foreach (drained[k])
      chk_byte(drained[k], 8'hA0 + 8'(k));
    txact = 1'b1;
    i_host.tick(10);
    one(STB_NO_OP, 8'h68);
    txact = 1'b0;
    one(STB_NO_OP, 8'h60);
    one(STB_FLUSH_TX, 8'h60);
    one(STB_NO_OP, 8'h40);
    i_host.sel(1'b1);
    i_host.xfer(8'hE0, 8, r);
    chk_byte(r, 8'h40);
    i_host.xfer(8'h80, 8, r);
    for (int k = 1; k < 13; k++) begin
      i_host.xfer(8'h11 * 8'(k), 8, r);
      chk_byte(r, 8'h00);
    end
    i_host.sel(1'b0);
    chk_port(long_id, 64'h8877665544332211);
    chk_port({net_id, short_id}, {16'hAA99, 16'hCCBB});
    i_host.sel(1'b1);
    i_host.xfer(8'hE0, 8, r);
    i_host.xfer(8'hA0, 8, r);
    for (int k = 1; k < 5; k++) begin
      i_host.xfer(8'h00, 8, r);
      chk_byte(r, 8'h11 * 8'(k));
    end
    i_host.sel(1'b0);
    rxq_data = 8'h5A;
    rxq_we = 1'b1;
    i_host.tick(1);
    rxq_we = 1'b0;
    i_host.sel(1'b1);
    i_host.xfer(8'h7F, 8, r);
    chk_byte(r, 8'h40);
    i_host.xfer(8'h00, 8, r);
    chk_byte(r, 8'h5A);
    i_host.sel(1'b0);
    p0 = npulse;
    i_host.sel(1'b1);
    i_host.xfer(8'h00, 4, r);
    i_host.sel(1'b0);
    one(STB_FLUSH_TX, 8'h40);
    chk_port(64'(npulse - p0), 64'h1);
    chk_port(code_seen, STB_FLUSH_TX);
    rst = 1'b1;
    i_host.tick(2);
    rst = 1'b0;
    i_host.tick(4);
    chk_port(long_id, 64'h0);
    chk_port({net_id, short_id, so_oe_n}, {32'h0, 1'b1});
    one(STB_NO_OP, 8'h40);
    final_report();
  end
endmodule
